// [common/timer_pkg.sv]
package timer_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PRESC_W = 8;

  // Register addresses
  localparam logic [15:0] CTRL_ADDR   = 16'h0100;
  localparam logic [15:0] COUNT_ADDR  = 16'h0102;
  localparam logic [15:0] PERIOD_ADDR = 16'h0104;
  localparam logic [15:0] MDIS_ADDR   = 16'h0760;

  // Field positions in timer_control_reg
  localparam int unsigned SRC_BIT   = 1;
  localparam int unsigned SYNC_BIT  = 2;
  localparam int unsigned PRESC_LO  = 4;
  localparam int unsigned PRESC_HI  = 5;
  localparam int unsigned GATE_BIT  = 6;
  localparam int unsigned ON_BIT    = 15;
  // Field position in module_disable_reg_one
  localparam int unsigned TMR_DIS_BIT = 11;

  // Implemented bits; all others read as zero
  localparam logic [15:0] CTRL_MASK = 16'h8076;
  localparam logic [15:0] MDIS_MASK = 16'h0800;

  // Values after reset
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] MDIS_RESET   = 16'h0000;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 8'h00;

  // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [PRESC_W-1:0] PRESC_LIM_1   = 8'h00;
  localparam logic [PRESC_W-1:0] PRESC_LIM_8   = 8'h07;
  localparam logic [PRESC_W-1:0] PRESC_LIM_64  = 8'h3F;
  localparam logic [PRESC_W-1:0] PRESC_LIM_256 = 8'hFF;

  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_GATED,
    MODE_SYNC_CNT,
    MODE_ASYNC_CNT
  } mode_t;

  function automatic mode_t decode_mode(input logic src, input logic gate, input logic sync);
    mode_t m;
    if (!src) begin
      m = gate ? MODE_GATED : MODE_TIMER;
    end else begin
      m = sync ? MODE_SYNC_CNT : MODE_ASYNC_CNT;
    end
    return m;
  endfunction : decode_mode

endpackage : timer_pkg

// [verilog/pin_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module pin_sync
  import timer_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [1:0] async_i,
  output var  logic [1:0] sync_o
);

  logic [1:0] meta_q;
  logic [1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : pin_sync

`default_nettype wire

// [verilog/interval_timer.sv]
// Summary of operation
// - The timer is a 16-bit counter that runs free as an interval timer or counts external events.
// - An asynchronous counter mode advances on the external clock with no resync stage at the prescaler output.
// - When sync is selected, the external count clock gets a further resync stage after the prescaler, on top of the pin synchroniser before it.
// - Timer and gated timer modes count the instruction-cycle clock.
// - Synchronous and asynchronous counter modes count the external count clock pin.
// - The clock source select bit sits at bit 1 of the timer control register.
// - The external clock sync select bit sits at bit 2 of the timer control register.
// - The gate enable bit sits at bit 6 of the timer control register.
// - Source 0/gate 0 is timer, 0/1 gated timer, source 1/sync 1 sync counter, 1/0 async counter.
// - The module disable register resets to all zeros, leaving the timer enabled, and unused bits read zero.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none

module interval_timer
  import timer_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output var  logic [DATA_W-1:0] rd_data_o,
  input  wire logic              ext_count_clock_pin_i,
  input  wire logic              ext_gate_i,
  output var  logic [DATA_W-1:0] count_o,
  output var  logic              period_match_o,
  output var  logic              timer_active_o
);

  function automatic logic [PRESC_W-1:0] presc_limit(input logic [1:0] sel);
    logic [PRESC_W-1:0] lim;
    case (sel)
      2'h0:    lim = PRESC_LIM_1;
      2'h1:    lim = PRESC_LIM_8;
      2'h2:    lim = PRESC_LIM_64;
      default: lim = PRESC_LIM_256;
    endcase
    return lim;
  endfunction : presc_limit

  // Register state
  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] ctrl_d;
  logic [DATA_W-1:0] period_q;
  logic [DATA_W-1:0] period_d;
  logic [DATA_W-1:0] mdis_q;
  logic [DATA_W-1:0] mdis_d;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;

  // Counting state
  logic [DATA_W-1:0]  count_q;
  logic [DATA_W-1:0]  count_d;
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] presc_d;
  logic               sync_stage_q;
  logic               sync_stage_d;
  logic               ext_prev_q;
  logic               ext_prev_d;
  logic               match_q;
  logic               match_d;

  // Decoded control
  logic              clock_source_select;
  logic              ext_clock_sync_select;
  logic              gate_enable;
  logic              timer_on;
  logic              timer_disable_bit;
  logic [1:0]        presc_sel;
  mode_t             mode;
  logic              active;
  logic [1:0]        pins_s;
  logic              ext_s;
  logic              gate_s;
  logic              ext_rise;
  logic              presc_in;
  logic              presc_out;
  logic              count_tick;
  logic              ctrl_wr;
  logic              count_wr;
  logic              period_wr;
  logic              mdis_wr;

  // Both pins cross into clk_i before anything looks at them
  pin_sync u_pin_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({ext_gate_i, ext_count_clock_pin_i}),
    .sync_o    (pins_s)
  );

  assign ext_s  = pins_s[0];
  assign gate_s = pins_s[1];

  assign clock_source_select   = ctrl_q[SRC_BIT];
  assign ext_clock_sync_select = ctrl_q[SYNC_BIT];
  assign gate_enable           = ctrl_q[GATE_BIT];
  assign timer_on              = ctrl_q[ON_BIT];
  assign presc_sel             = ctrl_q[PRESC_HI:PRESC_LO];
  assign timer_disable_bit     = mdis_q[TMR_DIS_BIT];

  assign mode   = decode_mode(clock_source_select, gate_enable, ext_clock_sync_select);
  assign active = timer_on && !timer_disable_bit;

  assign ctrl_wr   = wr_i && (addr_i == CTRL_ADDR);
  assign count_wr  = wr_i && (addr_i == COUNT_ADDR);
  assign period_wr = wr_i && (addr_i == PERIOD_ADDR);
  assign mdis_wr   = wr_i && (addr_i == MDIS_ADDR);

  assign ext_rise = ext_s && !ext_prev_q;

  // Prescaler input selection
  always_comb begin
    presc_in = 1'b0;
    if (active) begin
      case (mode)
        MODE_TIMER:     presc_in = 1'b1;
        MODE_GATED:     presc_in = gate_s;
        MODE_SYNC_CNT:  presc_in = ext_rise;
        MODE_ASYNC_CNT: presc_in = ext_rise;
        default:        presc_in = 1'b0;
      endcase
    end
  end

  // Prescaler and post-prescaler sync stage
  always_comb begin
    presc_d      = presc_q;
    presc_out    = 1'b0;
    sync_stage_d = 1'b0;
    ext_prev_d   = ext_s;
    if (!active) begin
      presc_d = PRESC_RESET;
    end else if (presc_in) begin
      if (presc_q >= presc_limit(presc_sel)) begin
        presc_d   = PRESC_RESET;
        presc_out = 1'b1;
      end else begin
        presc_d = presc_q + 8'h01;
      end
    end
    // Resync sits after the divider so the divider sees every edge
    sync_stage_d = active && (mode == MODE_SYNC_CNT) && presc_out;
  end

  // Async mode takes the divider output straight; sync mode waits one stage
  assign count_tick = active && ((mode == MODE_SYNC_CNT) ? sync_stage_q : presc_out);

  // Counter
  always_comb begin
    count_d = count_q;
    match_d = 1'b0;
    if (count_wr) begin
      count_d = wr_data_i;
    end else if (count_tick) begin
      if (count_q == period_q) begin
        count_d = COUNT_RESET;
        match_d = 1'b1;
      end else begin
        count_d = count_q + 16'h0001;
      end
    end
  end

  // Register writes and read mux
  always_comb begin
    ctrl_d    = ctrl_q;
    period_d  = period_q;
    mdis_d    = mdis_q;
    rd_data_d = 16'h0000;
    if (ctrl_wr) begin
      ctrl_d = wr_data_i & CTRL_MASK;
    end
    if (period_wr) begin
      period_d = wr_data_i;
    end
    if (mdis_wr) begin
      mdis_d = wr_data_i & MDIS_MASK;
    end
    if (rd_i) begin
      case (addr_i)
        CTRL_ADDR:   rd_data_d = ctrl_q;
        COUNT_ADDR:  rd_data_d = count_q;
        PERIOD_ADDR: rd_data_d = period_q;
        MDIS_ADDR:   rd_data_d = mdis_q;
        default:     rd_data_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q       <= CTRL_RESET;
      period_q     <= PERIOD_RESET;
      mdis_q       <= MDIS_RESET;
      rd_data_q    <= 16'h0000;
      count_q      <= COUNT_RESET;
      presc_q      <= PRESC_RESET;
      sync_stage_q <= 1'b0;
      ext_prev_q   <= 1'b0;
      match_q      <= 1'b0;
    end else begin
      ctrl_q       <= ctrl_d;
      period_q     <= period_d;
      mdis_q       <= mdis_d;
      rd_data_q    <= rd_data_d;
      count_q      <= count_d;
      presc_q      <= presc_d;
      sync_stage_q <= sync_stage_d;
      ext_prev_q   <= ext_prev_d;
      match_q      <= match_d;
    end
  end

  assign rd_data_o      = rd_data_q;
  assign count_o        = count_q;
  assign period_match_o = match_q;
  assign timer_active_o = active;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence ctrl_write_s;
    ctrl_wr;
  endsequence

  sequence ctrl_settled_s;
    ##1 1'b1;
  endsequence

  count_wrap_a: assert property (
    count_tick && !count_wr && (count_q == period_q) |=> (count_q == 16'h0000) && period_match_o)
    else $error("counter did not wrap to zero at period match");

  count_step_a: assert property (
    count_tick && !count_wr && (count_q != period_q) |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter did not advance by one on tick");

  async_direct_a: assert property (
    (mode == MODE_ASYNC_CNT) && presc_out && !count_wr |=> (count_q != $past(count_q)) || period_match_o)
    else $error("async mode did not count divider output at once");

  sync_after_div_a: assert property (
    (mode == MODE_SYNC_CNT) && presc_out && active && !ctrl_wr && !mdis_wr |=> count_tick)
    else $error("sync mode tick not one cycle after divider output");

  timer_source_a: assert property (
    (mode == MODE_TIMER) && active |-> presc_in)
    else $error("timer mode not fed by instruction clock");

  ext_source_a: assert property (
    clock_source_select && presc_in |-> $rose(ext_s))
    else $error("counter mode fed by something other than pin edge");

  src_bit_a: assert property (
    ctrl_write_s ##0 ctrl_settled_s |-> clock_source_select == $past(wr_data_i[1]))
    else $error("clock source select not at bit 1");

  sync_bit_a: assert property (
    ctrl_write_s |=> ext_clock_sync_select == $past(wr_data_i[2]))
    else $error("sync select not at bit 2");

  gate_bit_a: assert property (
    ctrl_write_s |=> gate_enable == $past(wr_data_i[6]))
    else $error("gate enable not at bit 6");

  mode_decode_a: assert property (
    !clock_source_select && gate_enable |-> mode == MODE_GATED)
    else $error("source 0 gate 1 not decoded as gated timer");

  disable_unused_a: assert property (
    rd_i && (addr_i == MDIS_ADDR) |=> (rd_data_o & ~MDIS_MASK) == 16'h0000)
    else $error("unimplemented module disable bits read nonzero");

  disabled_hold_a: assert property (
    timer_disable_bit && !count_wr |=> $stable(count_q))
    else $error("counter moved while module disabled");

  gate_block_a: assert property (
    (mode == MODE_GATED) && !gate_s |-> !presc_in)
    else $error("gated mode counted with gate low");

  gate_count_a: assert property (
    (mode == MODE_GATED) && active && gate_s && (presc_sel == 2'h0) && !count_wr && (count_q != period_q)
    |=> count_q == $past(count_q) + 16'h0001)
    else $error("gated mode did not count with gate high");

  idle_presc_a: assert property (
    !active |=> presc_q == PRESC_RESET)
    else $error("divider not cleared while timer inactive");

  disabled_quiet_a: assert property (
    timer_disable_bit |=> !period_match_o)
    else $error("period match pulsed while module disabled");

  ctrl_mask_a: assert property (
    ctrl_write_s |=> ctrl_q == ($past(wr_data_i) & CTRL_MASK))
    else $error("control register kept unimplemented bits");

endmodule : interval_timer

`default_nettype wire

// [verif/ext_clock_source.sv]
`timescale 1ns/100ps
`default_nettype none

module ext_clock_source (
  input  wire logic clk_i,
  output var  logic pin_o
);
  // Pin rests low between bursts so no stray edge gets counted
  initial pin_o = 1'b0;

  // Half period is in device clocks; two or more keeps both levels visible
  task automatic send(input int n, input int half);
    repeat (n) begin
      @(posedge clk_i);
      pin_o <= 1'b1;
      repeat (half) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (half) @(posedge clk_i);
    end
  endtask : send
endmodule : ext_clock_source

`default_nettype wire

// [verif/sixteen_bit_interval_timer_bench.sv]
`timescale 1ns/100ps
`default_nettype none

module sixteen_bit_interval_timer_bench
  import timer_pkg::*;
;
  logic              clk_i      = 1'b0;
  logic              reset_n_i  = 1'b0;
  logic [ADDR_W-1:0] addr_i     = '0;
  logic [DATA_W-1:0] wr_data_i  = '0;
  logic              wr_i       = 1'b0;
  logic              rd_i       = 1'b0;
  logic              ext_gate_i = 1'b0;
  wire  logic        pin;
  logic [DATA_W-1:0] rd_data_o;
  logic [DATA_W-1:0] count_o;
  logic              period_match_o;
  logic              timer_active_o;
  int                n_fail     = 0;
  int                num_checks = 0;
  logic [15:0]       v;
  int                p, g, n, h, la, ls;
  logic [15:0]       tmode [4] = '{16'h8000, 16'h8004, 16'h8040, 16'h8044};
  logic [15:0]       cmode [4] = '{16'h8002, 16'h8006, 16'h8042, 16'h8046};

  always #12.5 clk_i = ~clk_i;

  interval_timer u_interval_timer (
    .clk_i                (clk_i),
    .reset_n_i            (reset_n_i),
    .addr_i               (addr_i),
    .wr_data_i            (wr_data_i),
    .wr_i                 (wr_i),
    .rd_i                 (rd_i),
    .rd_data_o            (rd_data_o),
    .ext_count_clock_pin_i(pin),
    .ext_gate_i           (ext_gate_i),
    .count_o              (count_o),
    .period_match_o       (period_match_o),
    .timer_active_o       (timer_active_o)
  );

  ext_clock_source u_ext_clock_source (
    .clk_i(clk_i),
    .pin_o(pin)
  );

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk_val(what, exp, rd_data_o);
  endtask : rd_chk

  task automatic match_gap(output int c);
    int i;
    for (i = 0; i < 300 && period_match_o !== 1'b1; i++) @(negedge clk_i);
    chk_val("count at match", 16'h0000, count_o);
    @(negedge clk_i);
    for (c = 1; c < 300 && period_match_o !== 1'b1; c++) @(negedge clk_i);
  endtask : match_gap

  // Counts clock cycles from one pin pulse to the count change
  task automatic pin_latency(output int l);
    logic [15:0] c0;
    c0 = count_o;
    l  = 0;
    fork
      u_ext_clock_source.send(1, 3);
      while (count_o === c0 && l < 40) begin
        @(negedge clk_i);
        l++;
      end
    join
  endtask : pin_latency

  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    report_and_stop();
  end

  initial begin
    void'($urandom(50323));
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_chk("control", CTRL_ADDR, 16'h0000);
    rd_chk("period", PERIOD_ADDR, 16'hFFFF);
    rd_chk("disable", MDIS_ADDR, 16'h0000);
    rd_chk("unmapped", 16'h0106, 16'h0000);
    wr(MDIS_ADDR, 16'hFFFF);
    rd_chk("disable bits", MDIS_ADDR, 16'h0800);
    wr(MDIS_ADDR, 16'h0000);
    $display("test registers done");
    foreach (tmode[k]) begin
      p = 2 + $urandom % 39;
      wr(CTRL_ADDR, 16'h0000);
      wr(PERIOD_ADDR, p[15:0]);
      wr(COUNT_ADDR, 16'h0000);
      ext_gate_i <= 1'b1;
      wr(CTRL_ADDR, tmode[k]);
      match_gap(g);
      chk_val("match gap", p[15:0] + 16'h0001, g[15:0]);
    end
    @(posedge clk_i);
    ext_gate_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    v = count_o;
    repeat (10) @(negedge clk_i);
    chk_val("gate low hold", v, count_o);
    $display("test timer modes done");
    wr(CTRL_ADDR, 16'h0000);
    wr(PERIOD_ADDR, 16'h0003);
    wr(COUNT_ADDR, 16'h0000);
    wr(CTRL_ADDR, 16'h8010);
    match_gap(g);
    chk_val("divided gap", 16'h0020, g[15:0]);
    wr(CTRL_ADDR, 16'h8000);
    wr(MDIS_ADDR, 16'h0800);
    @(negedge clk_i);
    chk_val("active off", 16'h0000, {15'h0, timer_active_o});
    v = count_o;
    repeat (10) @(negedge clk_i);
    chk_val("disabled hold", v, count_o);
    wr(MDIS_ADDR, 16'h0000);
    @(negedge clk_i);
    chk_val("active on", 16'h0001, {15'h0, timer_active_o});
    $display("test disable done");
    wr(PERIOD_ADDR, 16'hFFFF);
    foreach (cmode[k]) begin
      n = 1 + $urandom % 6;
      h = 2 + $urandom % 3;
      wr(CTRL_ADDR, cmode[k]);
      wr(COUNT_ADDR, 16'h0000);
      repeat (10) @(negedge clk_i);
      chk_val("counter idle", 16'h0000, count_o);
      u_ext_clock_source.send(n, h);
      repeat (8) @(negedge clk_i);
      chk_val("pin edges", n[15:0], count_o);
    end
    wr(MDIS_ADDR, 16'h0800);
    v = count_o;
    u_ext_clock_source.send(3, 2);
    repeat (8) @(negedge clk_i);
    chk_val("disabled pin", v, count_o);
    wr(MDIS_ADDR, 16'h0000);
    wr(CTRL_ADDR, 16'h8002);
    pin_latency(la);
    wr(CTRL_ADDR, 16'h8006);
    pin_latency(ls);
    chk_val("sync lag", la[15:0] + 16'h0001, ls[15:0]);
    $display("test counter modes done");
    report_and_stop();
  end
endmodule : sixteen_bit_interval_timer_bench

`default_nettype wire
